// >>> core/gpio_port_pkg.sv
// shared constants for the gpio port block
package gpio_port_pkg;
	localparam int unsigned PAD_COUNT = 8;
	localparam int unsigned ADDR_W = 12;
	// register indexes; the apb byte address is four times the index
	localparam logic [11:0] IDX_DRIVE_ENABLE = 12'h0_000;
	localparam logic [11:0] IDX_DRIVE_ENABLE_SET = 12'h0_001;
	localparam logic [11:0] IDX_DRIVE_ENABLE_CLEAR = 12'h0_002;
	localparam logic [11:0] IDX_DRIVE_ENABLE_FLIP = 12'h0_003;
	localparam logic [11:0] IDX_DRIVE_LEVEL = 12'h0_004;
	localparam logic [11:0] IDX_DRIVE_LEVEL_SET = 12'h0_005;
	localparam logic [11:0] IDX_DRIVE_LEVEL_CLEAR = 12'h0_006;
	localparam logic [11:0] IDX_DRIVE_LEVEL_FLIP = 12'h0_007;
	localparam logic [11:0] IDX_PAD_INPUT = 12'h0_008;
	localparam logic [11:0] IDX_PAD_EVENT_FLAGS = 12'h0_009;
	localparam logic [11:0] IDX_PAD0_CONFIG = 12'h0_010;
	// fast alias block: direction, level, input, flags
	localparam logic [11:0] IDX_FAST_ALIAS_BASE = 12'h0_040;
	localparam logic [11:0] IDX_WAKE_STATUS = 12'h0_020;
	// pad_config field layout
	localparam int unsigned CFG_INVERT_BIT = 7;
	localparam int unsigned CFG_PULL_BIT = 3;
	localparam int unsigned CFG_SENSE_LSB = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CFG_MASK = 8'h8F;
	// input buffers come out of reset enabled on every pad
	localparam logic [7:0] INPUT_ENABLE_RESET = 8'hFF;
	// synchronous sense dead time after an accepted interrupt
	localparam logic [1:0] DEAD_CYCLES = 2'h3;
	typedef enum logic [2:0] {
		sense_any_edge = 3'h0,
		sense_rising = 3'h1,
		sense_falling = 3'h2,
		sense_input_off = 3'h4,
		sense_low_level = 3'h5
	} sense_select_t;
endpackage : gpio_port_pkg

// >>> core/pad_sense.sv
// one pad: input synchroniser, edge sense, flag, event and wake outputs
`timescale 1ns/1ps
`default_nettype none
module pad_sense (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic pad_in,
	input wire logic invert,
	input wire logic [2:0] sense_sel,
	input wire logic flag_clear,
	output logic sampled,
	output logic flag,
	output logic event_out,
	output logic wake
);
	import gpio_port_pkg::*;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic [2:0] sense_prev_q;
	logic [1:0] dead_q;
	logic in_on;
	logic rise;
	logic fall;
	logic hit;
	logic level_now;

	assign in_on = (sense_sel != 3'(sense_input_off));
	// inversion applied before the synchroniser so a polarity change is an edge
	assign level_now = pad_in ^ invert;

	// synchroniser stops while input is off; stale value resumes later
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (in_on) begin
			sync1_q <= level_now;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign sampled = sync2_q;
	assign rise = sync2_q & ~prev_q;
	assign fall = ~sync2_q & prev_q;

	// edge or level qualifying per sense setting
	always_comb begin
		unique case (sense_sel)
			3'(sense_any_edge): hit = rise | fall;
			3'(sense_rising): hit = rise;
			3'(sense_falling): hit = fall;
			3'(sense_low_level): hit = ~sync2_q;
			default: hit = 1'b0;
		endcase
	end

	// sense change discards the edge in flight; dead time after each accept
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sense_prev_q <= 3'(sense_input_off);
			dead_q <= 2'h0;
			flag <= 1'b0;
		end else begin
			sense_prev_q <= sense_sel;
			if (hit && dead_q == 2'h0 && sense_prev_q == sense_sel) begin
				flag <= 1'b1; // set beats clear
				dead_q <= DEAD_CYCLES;
			end else begin
				if (flag_clear)
					flag <= 1'b0;
				if (dead_q != 2'h0)
					dead_q <= dead_q - 2'h1;
			end
		end
	end

	// event carries pad level only with input enabled
	assign event_out = in_on & level_now;
	// partly asynchronous pad: wake only for both-edge or level sensing
	assign wake = flag & ((sense_sel == 3'(sense_any_edge))
		| (sense_sel == 3'(sense_low_level)));

	// an accept must run its full countdown; a reload inside it is a re-accept
	property p_dead_time;
		@(posedge sys_clk) disable iff (!arst_n)
		(dead_q == DEAD_CYCLES) |=> (dead_q == 2'h2) ##1 (dead_q == 2'h1) ##1 (dead_q == 2'h0);
	endproperty
	a_dead_time: assert property (p_dead_time) else $error("accept inside dead time");
endmodule : pad_sense
`default_nettype wire

// >>> core/gpio_port.sv
// gpio port top: apb register file, pad drivers and per-pad sensing
`timescale 1ns/1ps
`default_nettype none
module gpio_port (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpio_port_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [gpio_port_pkg::PAD_COUNT-1:0] pad_in,
	output logic [gpio_port_pkg::PAD_COUNT-1:0] pad_out,
	output logic [gpio_port_pkg::PAD_COUNT-1:0] pad_oe,
	output logic [gpio_port_pkg::PAD_COUNT-1:0] pad_pull_high_enable,
	output logic [gpio_port_pkg::PAD_COUNT-1:0] pad_input_enable,
	output logic [gpio_port_pkg::PAD_COUNT-1:0] pad_event,
	output logic port_irq,
	output logic port_wake
);
	import gpio_port_pkg::*;
	logic [PAD_COUNT-1:0] drive_enable_q;
	logic [PAD_COUNT-1:0] drive_level_q;
	logic [7:0] pad_config_q [PAD_COUNT];
	logic [PAD_COUNT-1:0] sampled;
	logic [PAD_COUNT-1:0] flag;
	logic [PAD_COUNT-1:0] evt;
	logic [PAD_COUNT-1:0] wake;
	logic [PAD_COUNT-1:0] invert;
	logic [PAD_COUNT-1:0] flag_clear;
	logic [PAD_COUNT-1:0] input_on;
	logic [ADDR_W-1:0] idx;
	logic [ADDR_W-1:0] alias_off;
	logic is_alias;
	logic setup;
	logic wr;
	logic mapped;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	// one register kind decode, shared by regular and alias windows
	logic hit_dir;
	logic hit_dir_set;
	logic hit_dir_clr;
	logic hit_dir_flip;
	logic hit_lvl;
	logic hit_lvl_set;
	logic hit_lvl_clr;
	logic hit_lvl_flip;
	logic hit_in;
	logic hit_flags;
	logic hit_cfg;
	logic hit_wake;
	logic [2:0] cfg_sel;

	// word addressing: index is the byte address over four
	assign idx = {2'b00, paddr[ADDR_W-1:2]};
	assign alias_off = idx - IDX_FAST_ALIAS_BASE;
	assign is_alias = (idx >= IDX_FAST_ALIAS_BASE) && (alias_off < 12'h0_004);
	assign setup = psel & ~penable;
	// zero-wait slave: access happens in the cycle after setup
	assign wr = psel & penable & pwrite & pstrb[0];
	assign wbyte = pwdata[7:0];

	// alias block maps to direction, level, input and flags
	assign hit_dir = (idx == IDX_DRIVE_ENABLE) | (is_alias && alias_off == 12'h0_000);
	assign hit_lvl = (idx == IDX_DRIVE_LEVEL) | (is_alias && alias_off == 12'h0_001);
	assign hit_in = (idx == IDX_PAD_INPUT) | (is_alias && alias_off == 12'h0_002);
	assign hit_flags = (idx == IDX_PAD_EVENT_FLAGS) | (is_alias && alias_off == 12'h0_003);
	assign hit_dir_set = (idx == IDX_DRIVE_ENABLE_SET);
	assign hit_dir_clr = (idx == IDX_DRIVE_ENABLE_CLEAR);
	assign hit_dir_flip = (idx == IDX_DRIVE_ENABLE_FLIP);
	assign hit_lvl_set = (idx == IDX_DRIVE_LEVEL_SET);
	assign hit_lvl_clr = (idx == IDX_DRIVE_LEVEL_CLEAR);
	assign hit_lvl_flip = (idx == IDX_DRIVE_LEVEL_FLIP);
	// pad n config at 0x10 + n
	assign hit_cfg = (idx >= IDX_PAD0_CONFIG) && (idx < IDX_PAD0_CONFIG + 12'(PAD_COUNT));
	assign cfg_sel = idx[2:0];
	assign hit_wake = (idx == IDX_WAKE_STATUS);
	assign mapped = hit_dir | hit_lvl | hit_in | hit_flags | hit_dir_set | hit_dir_clr
		| hit_dir_flip | hit_lvl_set | hit_lvl_clr | hit_lvl_flip | hit_cfg | hit_wake;

	// direction register and its strobes; reset leaves every driver off
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_enable_q <= REG_RESET;
		end else if (wr) begin
			if (hit_dir)
				drive_enable_q <= wbyte;
			else if (hit_dir_set)
				drive_enable_q <= drive_enable_q | wbyte;
			else if (hit_dir_clr)
				drive_enable_q <= drive_enable_q & ~wbyte;
			else if (hit_dir_flip)
				drive_enable_q <= drive_enable_q ^ wbyte;
		end
	end

	// drive level register; a write to the input register toggles too
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_level_q <= REG_RESET;
		end else if (wr) begin
			if (hit_lvl)
				drive_level_q <= wbyte;
			else if (hit_lvl_set)
				drive_level_q <= drive_level_q | wbyte;
			else if (hit_lvl_clr)
				drive_level_q <= drive_level_q & ~wbyte;
			else if (hit_lvl_flip || hit_in)
				drive_level_q <= drive_level_q ^ wbyte;
		end
	end

	// per-pad configuration storage and sensing, one instance per pad
	for (genvar n = 0; n < PAD_COUNT; n++) begin : g_pad
		always_ff @(posedge sys_clk or negedge arst_n) begin
			if (!arst_n)
				pad_config_q[n] <= CFG_RESET;
			else if (wr && hit_cfg && cfg_sel == 3'(n))
				pad_config_q[n] <= wbyte & CFG_MASK;
		end
		assign invert[n] = pad_config_q[n][CFG_INVERT_BIT];
		assign input_on[n] = pad_config_q[n][CFG_SENSE_LSB+:3] != 3'(sense_input_off);
		// write-one-to-clear on the flag register
		assign flag_clear[n] = wr & hit_flags & wbyte[n];
		pad_sense pad_sense_i (
			.sys_clk(sys_clk),
			.arst_n(arst_n),
			.pad_in(pad_in[n]),
			.invert(invert[n]),
			.sense_sel(pad_config_q[n][CFG_SENSE_LSB+:3]),
			.flag_clear(flag_clear[n]),
			.sampled(sampled[n]),
			.flag(flag[n]),
			.event_out(evt[n]),
			.wake(wake[n])
		);
		// stored config and the pull driver must follow the written byte
		property p_cfg_write;
			@(posedge sys_clk) disable iff (!arst_n)
			(wr && hit_cfg && cfg_sel == 3'(n))
				|=> (pad_config_q[n] == ($past(wbyte) & CFG_MASK));
		endproperty
		a_cfg_write: assert property (p_cfg_write) else $error("pad config write lost");
		property p_pull_out;
			@(posedge sys_clk) disable iff (!arst_n)
			1'b1 |=> (pad_pull_high_enable[n] == $past(pad_config_q[n][CFG_PULL_BIT]));
		endproperty
		a_pull_out: assert property (p_pull_out) else $error("pull enable mismatch");
	end

	// read mux; set strobe reads back direction
	always_comb begin
		rbyte = 8'h00;
		if (hit_dir || hit_dir_set || hit_dir_clr || hit_dir_flip)
			rbyte = drive_enable_q;
		else if (hit_lvl || hit_lvl_set || hit_lvl_clr || hit_lvl_flip)
			rbyte = drive_level_q;
		else if (hit_in)
			rbyte = sampled;
		else if (hit_flags)
			rbyte = flag;
		else if (hit_cfg)
			rbyte = pad_config_q[cfg_sel];
		else if (hit_wake)
			rbyte = wake;
	end

	// registered apb answer: pready one cycle after setup, error if unmapped
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup && !pwrite) ? {24'h00_0000, rbyte} : 32'h0000_0000;
		end
	end

	// pad drive: invert applies to the driven level; no debug input exists
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pad_out <= REG_RESET;
			pad_oe <= REG_RESET;
			pad_pull_high_enable <= REG_RESET;
			pad_input_enable <= INPUT_ENABLE_RESET; // input buffers on from reset
		end else begin
			pad_out <= drive_level_q ^ invert;
			pad_oe <= drive_enable_q;
			for (int i = 0; i < PAD_COUNT; i++) begin
				pad_pull_high_enable[i] <= pad_config_q[i][CFG_PULL_BIT];
			end
			pad_input_enable <= input_on;
		end
	end

	// interrupt, wake and event outputs from flops; request holds until clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_irq <= 1'b0;
			port_wake <= 1'b0;
			pad_event <= REG_RESET;
		end else begin
			port_irq <= |flag;
			port_wake <= |wake;
			pad_event <= evt;
		end
	end

	// assertions
	property p_set_strobe;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_dir_set) |=> (drive_enable_q == ($past(drive_enable_q) | $past(wbyte)));
	endproperty
	a_set_strobe: assert property (p_set_strobe) else $error("dir set lost");
	property p_clr_strobe;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_dir_clr) |=> (drive_enable_q == ($past(drive_enable_q) & ~$past(wbyte)));
	endproperty
	a_clr_strobe: assert property (p_clr_strobe) else $error("dir clear wrong");
	property p_flip_strobe;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_dir_flip) |=> (drive_enable_q == ($past(drive_enable_q) ^ $past(wbyte)));
	endproperty
	a_flip_strobe: assert property (p_flip_strobe) else $error("dir flip wrong");
	property p_lvl_set;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_lvl_set) |=> (drive_level_q == ($past(drive_level_q) | $past(wbyte)));
	endproperty
	a_lvl_set: assert property (p_lvl_set) else $error("level set wrong");
	property p_lvl_clr;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_lvl_clr) |=> (drive_level_q == ($past(drive_level_q) & ~$past(wbyte)));
	endproperty
	a_lvl_clr: assert property (p_lvl_clr) else $error("level clear wrong");
	property p_in_toggle;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_in) |=> (drive_level_q == ($past(drive_level_q) ^ $past(wbyte)));
	endproperty
	a_in_toggle: assert property (p_in_toggle) else $error("input write no toggle");
	property p_drive_out;
		@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> (pad_out == ($past(drive_level_q) ^ $past(invert))
			&& pad_oe == $past(drive_enable_q));
	endproperty
	a_drive_out: assert property (p_drive_out) else $error("pad drive mismatch");
	property p_irq_holds;
		@(posedge sys_clk) disable iff (!arst_n)
		(flag != 8'h00 && !(wr && hit_flags)) |=> ##1 port_irq;
	endproperty
	a_irq_holds: assert property (p_irq_holds) else $error("irq dropped");
	property p_event_off;
		@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> ((pad_event & ~$past(input_on)) == 8'h00);
	endproperty
	a_event_off: assert property (p_event_off) else $error("event while input off");
	property p_set_read;
		@(posedge sys_clk) disable iff (!arst_n)
		(setup && !pwrite && hit_dir_set) |=> (prdata[7:0] == drive_enable_q);
	endproperty
	a_set_read: assert property (p_set_read) else $error("set readback wrong");
	// plain writes and the level flip strobe, alias window included
	property p_lvl_flip;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_lvl_flip) |=> (drive_level_q == ($past(drive_level_q) ^ $past(wbyte)));
	endproperty
	a_lvl_flip: assert property (p_lvl_flip) else $error("level flip wrong");
	property p_dir_write;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_dir) |=> (drive_enable_q == $past(wbyte));
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");
	property p_lvl_write;
		@(posedge sys_clk) disable iff (!arst_n)
		(wr && hit_lvl) |=> (drive_level_q == $past(wbyte));
	endproperty
	a_lvl_write: assert property (p_lvl_write) else $error("level write lost");
	// registers move only when their own strobes are written, and level also when the input register is written
	property p_dir_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		!(wr && (hit_dir || hit_dir_set || hit_dir_clr || hit_dir_flip))
			|=> $stable(drive_enable_q);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction changed unasked");
	property p_lvl_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		!(wr && (hit_lvl || hit_lvl_set || hit_lvl_clr || hit_lvl_flip || hit_in))
			|=> $stable(drive_level_q);
	endproperty
	a_lvl_hold: assert property (p_lvl_hold) else $error("level changed unasked");
	// pad side outputs follow configuration and flags one cycle late
	property p_input_enable;
		@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> (pad_input_enable == $past(input_on));
	endproperty
	a_input_enable: assert property (p_input_enable) else $error("input enable mismatch");
	property p_irq_idle;
		@(posedge sys_clk) disable iff (!arst_n)
		(flag == 8'h00) |=> (port_irq == 1'b0);
	endproperty
	a_irq_idle: assert property (p_irq_idle) else $error("irq without flag");
	property p_wake_out;
		@(posedge sys_clk) disable iff (!arst_n)
		(wake != 8'h00) |=> port_wake;
	endproperty
	a_wake_out: assert property (p_wake_out) else $error("wake request lost");
	property p_wake_idle;
		@(posedge sys_clk) disable iff (!arst_n)
		(wake == 8'h00) |=> (port_wake == 1'b0);
	endproperty
	a_wake_idle: assert property (p_wake_idle) else $error("wake without cause");
endmodule : gpio_port
`default_nettype wire

// >>> tb/pad_model.sv
// pad partner: resolves each pad level from port driver, outside driver and pull
`timescale 1ns/1ps
`default_nettype none
module pad_model (
	input wire logic sys_clk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pull_high_enable,
	input wire logic [7:0] ext_level,
	input wire logic [7:0] ext_drive,
	output logic [7:0] pad_level
);
	logic [7:0] float_q = 8'h55;
	// floating pads wander so a stale level never passes for a real one
	always @(posedge sys_clk) begin
		float_q <= ~float_q;
	end
	// port driver wins, then outside driver, then pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) begin
				pad_level[i] = pad_out[i];
			end else if (ext_drive[i]) begin
				pad_level[i] = ext_level[i];
			end else begin
				pad_level[i] = pad_pull_high_enable[i] ? 1'b1 : float_q[i];
			end
		end
	end
endmodule : pad_model
`default_nettype wire

// >>> tb/gpio_port_tb.sv
// bench for the gpio port: apb tasks, pad stimulus and scenarios
`timescale 1ns/1ps
`default_nettype none
module gpio_port_tb;
	import gpio_port_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic port_irq;
	logic port_wake;
	logic [7:0] pad_in;
	logic [7:0] pad_out;
	logic [7:0] pad_oe;
	logic [7:0] pad_pull;
	logic [7:0] pad_ien;
	logic [7:0] pad_event;
	logic [7:0] ext_level = 8'h00;
	logic [7:0] rd;
	logic err;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;

	gpio_port gpio_port_i (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pull_high_enable(pad_pull), .pad_input_enable(pad_ien),
		.pad_event(pad_event), .port_irq(port_irq), .port_wake(port_wake));
	pad_model pad_model_i (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_high_enable(pad_pull), .ext_level(ext_level), .ext_drive(8'hFF),
		.pad_level(pad_in));

	// 100 mhz clock
	always #5 sys_clk = ~sys_clk;

	// hang guard: the whole run needs well under this many cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= idx << 2;
		pwdata <= {24'h00_0000, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd);
	endtask : wr

	task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask : rchk

	task automatic t_reset();
		chk(pad_oe, 8'h00);
		chk(pad_ien, 8'hFF);
		rchk(IDX_DRIVE_ENABLE, REG_RESET);
		rchk(IDX_DRIVE_LEVEL, REG_RESET);
		rchk(IDX_PAD0_CONFIG, CFG_RESET);
	endtask : t_reset

	// direction strobes touch only the written-one bits
	task automatic t_dir();
		wr(IDX_DRIVE_ENABLE_SET, 8'h05);
		rchk(IDX_DRIVE_ENABLE, 8'h05);
		wr(IDX_DRIVE_ENABLE_CLEAR, 8'h01);
		rchk(IDX_DRIVE_ENABLE, 8'h04);
		wr(IDX_DRIVE_ENABLE_FLIP, 8'h0C);
		rchk(IDX_DRIVE_ENABLE_SET, 8'h08);
		chk(pad_oe, 8'h08);
		apb(1'b0, 12'h00A, 8'h00);
		chk({7'h00, err}, 8'h01);
	endtask : t_dir

	task automatic t_level();
		wr(IDX_FAST_ALIAS_BASE + 12'h001, 8'h5A);
		rchk(IDX_DRIVE_LEVEL, 8'h5A);
		wr(IDX_DRIVE_LEVEL, 8'h0F);
		wr(IDX_DRIVE_LEVEL_SET, 8'h30);
		rchk(IDX_DRIVE_LEVEL, 8'h3F);
		wr(IDX_DRIVE_LEVEL_CLEAR, 8'h03);
		rchk(IDX_DRIVE_LEVEL, 8'h3C);
		wr(IDX_DRIVE_LEVEL_FLIP, 8'h81);
		wr(IDX_PAD_INPUT, 8'h01);
		rchk(IDX_DRIVE_LEVEL, 8'hBC);
		wr(IDX_DRIVE_ENABLE, 8'hFF);
		repeat (4) @(posedge sys_clk);
		chk(pad_out, 8'hBC);
		rchk(IDX_PAD_INPUT, 8'hBC);
	endtask : t_level

	// invert on pad 2; sense is left alone so the edge is not lost
	task automatic t_config();
		wr(IDX_PAD0_CONFIG + 12'h002, 8'h88);
		rchk(IDX_PAD0_CONFIG + 12'h002, 8'h88);
		repeat (4) @(posedge sys_clk);
		chk(pad_pull, 8'h04);
		chk(pad_out, 8'hB8);
		rchk(IDX_PAD_INPUT, 8'hBC);
		wr(IDX_DRIVE_ENABLE, 8'h00);
		wr(IDX_PAD0_CONFIG + 12'h002, 8'h00);
		repeat (6) @(posedge sys_clk);
		wr(IDX_PAD_EVENT_FLAGS, 8'hFF);
		wr(IDX_PAD0_CONFIG + 12'h002, 8'h80);
		repeat (6) @(posedge sys_clk);
		rchk(IDX_PAD_EVENT_FLAGS, 8'h04);
		chk({7'h00, port_irq}, 8'h01);
		chk({7'h00, port_wake}, 8'h01);
		wr(IDX_PAD_EVENT_FLAGS, 8'h04);
		repeat (2) @(posedge sys_clk);
		chk({7'h00, port_irq}, 8'h00);
		wr(IDX_PAD0_CONFIG + 12'h002, 8'h00);
	endtask : t_config

	// pad 4 moves from s0 to s1 under one sense setting
	task automatic sense_case(input logic [2:0] sel, input logic s0, input logic s1,
		input logic hit);
		wr(IDX_PAD0_CONFIG + 12'h004, {5'h00, sel});
		ext_level[4] <= s0;
		repeat (6) @(posedge sys_clk);
		wr(IDX_PAD_EVENT_FLAGS, 8'hFF);
		ext_level[4] <= s1;
		repeat (6) @(posedge sys_clk);
		rchk(IDX_PAD_EVENT_FLAGS, {3'h0, hit, 4'h0});
		chk({7'h00, pad_event[4]}, {7'h00, s1 & (sel != 3'h4)});
		chk({7'h00, pad_ien[4]}, {7'h00, sel != 3'h4});
		chk({7'h00, port_wake}, {7'h00, hit & (sel == 3'h0 || sel == 3'h5)});
	endtask : sense_case

	task automatic t_sense();
		sense_case(sense_any_edge, 1'b0, 1'b1, 1'b1);
		sense_case(sense_rising, 1'b1, 1'b0, 1'b0);
		sense_case(sense_rising, 1'b0, 1'b1, 1'b1);
		sense_case(sense_falling, 1'b0, 1'b1, 1'b0);
		sense_case(sense_falling, 1'b1, 1'b0, 1'b1);
		sense_case(sense_low_level, 1'b1, 1'b0, 1'b1);
		sense_case(sense_input_off, 1'b0, 1'b1, 1'b0);
	endtask : t_sense

	// reset held ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_reset();
		t_dir();
		t_level();
		t_config();
		t_sense();
		summarize();
	end
endmodule : gpio_port_tb
`default_nettype wire
